//--- design/abu_top.sv
module abu_top
   import abu_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              arst_n,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ABU_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // cpu core internal buses
   input  wire logic [15:0]       cpu_addr,
   input  wire logic [15:0]       cpu_data,
   input  wire logic              cpu_exec,
   input  wire logic              cpu_rd,
   input  wire logic              cpu_wr,
   input  wire logic              cpu_rte,
   input  wire logic              cpu_instr_done,
   // outputs to the core
   output logic                   rte_mask,
   output logic                   break_irq,
   output logic                   irq
);

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   typedef struct packed {
      logic [7:0]  ctrl;
      logic        flag;
      logic        ie;
      logic        armed;
      logic [15:0] baddr;
      logic [15:0] bdata;
      logic [1:0]  evt;
      logic [1:0]  emask;
      logic        rte_mask;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic        break_irq;
      logic        irq;
   } abu_state_s;

   abu_state_s st_r;
   abu_state_s st_nxt;

   // ---------------------------------------------
   // decode helpers
   // ---------------------------------------------
   // word index from byte address; low two bits ignored
   function automatic logic [15:0] abu_idx(input logic [ABU_AW-1:0] a);
      abu_idx = a[ABU_AW-1:2];
   endfunction : abu_idx

   function automatic logic abu_hit(input logic [ABU_AW-1:0] a);
      logic [15:0] i;
      i = abu_idx(a);
      abu_hit = (i == ABU_IDX_CTRL) || (i == ABU_IDX_STAT) || (i == ABU_IDX_BADDR)
             || (i == ABU_IDX_BDATA) || (i == ABU_IDX_EVT) || (i == ABU_IDX_EMASK);
   endfunction : abu_hit

   // ---------------------------------------------
   // break condition
   // ---------------------------------------------
   logic [1:0] csel;
   logic [2:0] acmp;
   logic [1:0] dcmp;
   logic       cyc_ok;
   logic       addr_ok;
   logic       data_ok;
   logic       match;

   assign csel = st_r.ctrl[ABU_CSEL_HI:ABU_CSEL_LO];
   assign acmp = st_r.ctrl[ABU_ACMP_HI:ABU_ACMP_LO];
   assign dcmp = st_r.ctrl[ABU_DCMP_HI:ABU_DCMP_LO];

   // cycle qualifier picked by the cycle select code
   always_comb begin
      case (csel)
         ABU_CSEL_EXEC: cyc_ok = cpu_exec;
         ABU_CSEL_RD:   cyc_ok = cpu_rd;
         ABU_CSEL_WR:   cyc_ok = cpu_wr;
         default:       cyc_ok = cpu_rd | cpu_wr;
      endcase
   end

   // other codes only look at the upper byte, a page-wide break
   always_comb begin
      if (acmp == ABU_ACMP_FULL) begin
         addr_ok = (cpu_addr == st_r.baddr);
      end else begin
         addr_ok = (cpu_addr[15:8] == st_r.baddr[15:8]);
      end
   end

   // data term is forced true when comparison is off
   always_comb begin
      case (dcmp)
         ABU_DCMP_NONE: data_ok = 1'b1;
         ABU_DCMP_LOW:  data_ok = (cpu_data[7:0] == st_r.bdata[7:0]);
         ABU_DCMP_HIGH: data_ok = (cpu_data[15:8] == st_r.bdata[15:8]);
         default:       data_ok = (cpu_data == st_r.bdata);
      endcase
   end

   assign match = cyc_ok & addr_ok & data_ok;

   // ---------------------------------------------
   // apb phases
   // ---------------------------------------------
   // access answered one cycle late so prdata comes from a flop
   logic        acc_first;
   logic        acc_done;
   logic        wr_done;
   logic        rd_done;
   logic [15:0] idx;
   logic [31:0] rd_word;

   assign acc_first = psel & penable & ~st_r.pready;
   assign acc_done  = psel & penable & st_r.pready;
   assign wr_done   = acc_done & pwrite & abu_hit(paddr);
   assign rd_done   = acc_done & ~pwrite & abu_hit(paddr);
   assign idx       = abu_idx(paddr);

   // read mux; reserved status bits read as ones
   always_comb begin
      rd_word = 32'h0000_0000;
      case (idx)
         ABU_IDX_CTRL:  rd_word[7:0]  = st_r.ctrl;
         ABU_IDX_STAT:  rd_word[7:0]  = {st_r.flag, st_r.ie, ABU_STAT_RSVD};
         ABU_IDX_BADDR: rd_word[15:0] = st_r.baddr;
         ABU_IDX_BDATA: rd_word[15:0] = st_r.bdata;
         ABU_IDX_EVT:   rd_word[1:0]  = st_r.evt;
         ABU_IDX_EMASK: rd_word[1:0]  = st_r.emask;
         default:       rd_word       = 32'h0000_0000;
      endcase
   end

   // ---------------------------------------------
   // next state
   // ---------------------------------------------
   logic wr_stat;
   logic clr_flag;
   logic rte_evt;

   assign wr_stat  = wr_done && (idx == ABU_IDX_STAT);
   // a zero write clears only after the flag was read as one
   assign clr_flag = wr_stat & ~pwdata[ABU_STAT_FLAG] & st_r.armed;
   assign rte_evt  = cpu_rte & ~st_r.ctrl[ABU_CTRL_RTINT];

   always_comb begin
      st_nxt = st_r;

      // bus handshake
      st_nxt.pready = acc_first;
      if (acc_first) begin
         st_nxt.prdata  = pwrite ? 32'h0000_0000 : rd_word;
         st_nxt.pslverr = ~abu_hit(paddr);
      end else begin
         st_nxt.prdata  = 32'h0000_0000;
         st_nxt.pslverr = 1'b0;
      end

      // register writes
      if (wr_done) begin
         case (idx)
            ABU_IDX_CTRL:  st_nxt.ctrl  = pwdata[7:0];
            ABU_IDX_STAT:  st_nxt.ie    = pwdata[ABU_STAT_IE];
            ABU_IDX_BADDR: st_nxt.baddr = pwdata[15:0];
            ABU_IDX_BDATA: st_nxt.bdata = pwdata[15:0];
            ABU_IDX_EMASK: st_nxt.emask = pwdata[1:0];
            default:       st_nxt.ctrl  = st_r.ctrl;
         endcase
      end

      // arm only on the flag value the read returned; a flag set during
      // the access phase was never seen by software and must not arm
      if (rd_done && (idx == ABU_IDX_STAT) && st_r.prdata[ABU_STAT_FLAG]) begin
         st_nxt.armed = 1'b1;
      end else if (clr_flag) begin
         st_nxt.armed = 1'b0;
      end

      // set beats clear in the same cycle
      if (match) begin
         st_nxt.flag = 1'b1;
      end else if (clr_flag) begin
         st_nxt.flag = 1'b0;
      end

      // sticky events, write one to clear, set wins
      if (wr_done && (idx == ABU_IDX_EVT)) begin
         st_nxt.evt = st_r.evt & ~pwdata[1:0];
      end
      if (match) begin
         st_nxt.evt[ABU_EVT_MATCH] = 1'b1;
      end
      if (rte_evt) begin
         st_nxt.evt[ABU_EVT_RTE] = 1'b1;
      end

      // hold-off after return: lifts when one more instruction retires
      if (rte_evt) begin
         st_nxt.rte_mask = 1'b1;
      end else if (cpu_instr_done) begin
         st_nxt.rte_mask = 1'b0;
      end

      // outputs follow the state just computed
      st_nxt.break_irq = st_nxt.flag & st_nxt.ie;
      st_nxt.irq = st_nxt.break_irq | (|(st_nxt.evt & st_nxt.emask));
   end

   // ---------------------------------------------
   // state register
   // ---------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r          <= '0;
         st_r.ctrl     <= ABU_CTRL_RST;
         st_r.baddr    <= ABU_BADDR_RST;
         st_r.bdata    <= ABU_BDATA_RST;
         st_r.evt      <= ABU_EVT_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata    = st_r.prdata;
   assign pready    = st_r.pready;
   assign pslverr   = st_r.pslverr;
   assign rte_mask  = st_r.rte_mask;
   assign break_irq = st_r.break_irq;
   assign irq       = st_r.irq;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking abu_cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   AST_RTE_MASK_SET: assert property (
      cpu_rte && !st_r.ctrl[ABU_CTRL_RTINT] |=> rte_mask)
      else $error("hold-off not raised after return");

   AST_RTE_NO_MASK: assert property (
      cpu_rte && st_r.ctrl[ABU_CTRL_RTINT] && !rte_mask |=> !rte_mask)
      else $error("hold-off raised while return interrupts enabled");

   AST_EXEC_BREAK: assert property (
      csel == ABU_CSEL_EXEC && cpu_exec && cpu_addr == st_r.baddr && dcmp == ABU_DCMP_NONE
      && acmp == ABU_ACMP_FULL |=> st_r.flag)
      else $error("execution break missed");

   AST_FULL_ADDR: assert property (
      acmp == ABU_ACMP_FULL && cpu_addr != st_r.baddr |-> !match)
      else $error("partial address matched in full mode");

   AST_NO_DATA: assert property (
      dcmp == ABU_DCMP_NONE && cyc_ok && addr_ok |-> match)
      else $error("data bus affected match with compare off");

   AST_FLAG_HOLD: assert property (
      st_r.flag && !clr_flag |=> st_r.flag)
      else $error("flag dropped without clear");

   AST_FLAG_CLEAR: assert property (
      !st_r.armed && !match |=> !$fell(st_r.flag))
      else $error("flag cleared without prior read");

   AST_RSVD_ONES: assert property (
      acc_first && !pwrite && idx == ABU_IDX_STAT |=> prdata[5:0] == ABU_STAT_RSVD)
      else $error("reserved status bits not one");

   AST_IRQ_LEVEL: assert property (
      break_irq == (st_r.flag && st_r.ie))
      else $error("break request does not follow flag and enable");

   AST_PREADY_ONE: assert property (
      pready |=> !pready)
      else $error("ready held over two cycles");

   // hold-off stays until an instruction retires, then lifts
   AST_RTE_HOLD: assert property (
      rte_mask && !cpu_instr_done |=> rte_mask)
      else $error("hold-off lifted before an instruction completed");

   AST_RTE_LIFT: assert property (
      rte_mask && cpu_instr_done && !cpu_rte |=> !rte_mask)
      else $error("hold-off kept after an instruction completed");

   AST_CYC_EXEC: assert property (
      csel == ABU_CSEL_EXEC && !cpu_exec |-> !match)
      else $error("break on a non-execution cycle");

   AST_FLAG_SET: assert property (
      match |=> st_r.flag && break_irq == st_r.ie)
      else $error("flag not set on a match");

   AST_FLAG_RISE: assert property (
      !match |=> !$rose(st_r.flag))
      else $error("flag set without a match");

   AST_FLAG_DROP: assert property (
      clr_flag && !match |=> !st_r.flag)
      else $error("flag kept after an armed zero write");

   AST_FLAG_ONE_WR: assert property (
      wr_stat && pwdata[ABU_STAT_FLAG] && !st_r.flag && !match |=> !st_r.flag)
      else $error("writing one set the flag");

   AST_ARM_READ: assert property (
      rd_done && idx == ABU_IDX_STAT && prdata[ABU_STAT_FLAG] |=> st_r.armed)
      else $error("read of a set flag did not arm the clear");

   AST_IE_MASK: assert property (
      !st_r.ie |-> !break_irq)
      else $error("request passed with enable off");

   AST_IE_PASS: assert property (
      st_r.ie && st_r.flag |-> break_irq)
      else $error("request blocked with enable on");

   AST_BADDR_READ: assert property (
      acc_first && !pwrite && idx == ABU_IDX_BADDR |=> prdata == {16'h0000, st_r.baddr})
      else $error("break address not returned as one word");

   AST_READY_ANSWER: assert property (
      acc_first |=> pready)
      else $error("no answer after the first access cycle");

   AST_ERR_UNMAPPED: assert property (
      acc_first && !abu_hit(paddr) |=> pready && pslverr)
      else $error("unmapped access not refused");

   AST_IRQ_OR: assert property (
      irq == (break_irq || (st_r.evt & st_r.emask) != 2'h0))
      else $error("interrupt line does not follow its sources");

endmodule : abu_top

//--- design/abu_pkg.sv
// Behaviour
// - after return-from-exception, mask interrupts one instruction
// - cycle select 00 breaks on execution cycles
// - address compare 000 compares full 16 bits
// - data compare 00 ignores the data bus
// - flag sets when all selected conditions match
// - flag clears on zero write after read-one
// - break interrupt enable masks or passes request
// - status bits five to zero read one
// - break address is one 16-bit value
package abu_pkg;
   // ---------------------------------------------
   // register indices; byte address is four times the index
   // ---------------------------------------------
   localparam logic [15:0] ABU_IDX_CTRL   = 16'hffc8;
   localparam logic [15:0] ABU_IDX_STAT   = 16'hffc9;
   localparam logic [15:0] ABU_IDX_BADDR  = 16'hffca;
   localparam logic [15:0] ABU_IDX_BDATA  = 16'hffcc;
   localparam logic [15:0] ABU_IDX_EVT    = 16'hffcd;
   localparam logic [15:0] ABU_IDX_EMASK  = 16'hffce;
   localparam int          ABU_AW         = 18;

   // ---------------------------------------------
   // field positions
   // ---------------------------------------------
   localparam int ABU_CTRL_RTINT = 7;
   localparam int ABU_CSEL_HI    = 6;
   localparam int ABU_CSEL_LO    = 5;
   localparam int ABU_ACMP_HI    = 4;
   localparam int ABU_ACMP_LO    = 2;
   localparam int ABU_DCMP_HI    = 1;
   localparam int ABU_DCMP_LO    = 0;
   localparam int ABU_STAT_FLAG  = 7;
   localparam int ABU_STAT_IE    = 6;
   localparam int ABU_EVT_MATCH  = 0;
   localparam int ABU_EVT_RTE    = 1;

   // ---------------------------------------------
   // reset values and fixed read values
   // ---------------------------------------------
   localparam logic [7:0]  ABU_CTRL_RST  = 8'h00;
   localparam logic [15:0] ABU_BADDR_RST = 16'h0000;
   localparam logic [15:0] ABU_BDATA_RST = 16'h0000;
   localparam logic [1:0]  ABU_EVT_RST   = 2'h0;
   localparam logic [5:0]  ABU_STAT_RSVD = 6'h3f;

   // ---------------------------------------------
   // condition encodings
   // ---------------------------------------------
   localparam logic [1:0] ABU_CSEL_EXEC  = 2'h0;
   localparam logic [1:0] ABU_CSEL_RD    = 2'h1;
   localparam logic [1:0] ABU_CSEL_WR    = 2'h2;
   localparam logic [2:0] ABU_ACMP_FULL  = 3'h0;
   localparam logic [1:0] ABU_DCMP_NONE  = 2'h0;
   localparam logic [1:0] ABU_DCMP_LOW   = 2'h1;
   localparam logic [1:0] ABU_DCMP_HIGH  = 2'h2;
endpackage : abu_pkg

//--- verification/abu_cpu_model.sv
module abu_cpu_model
   import abu_pkg::*;
(
   input  wire logic        clk,
   output logic      [15:0] cpu_addr,
   output logic      [15:0] cpu_data,
   output logic             cpu_exec,
   output logic             cpu_rd,
   output logic             cpu_wr,
   output logic             cpu_rte,
   output logic             cpu_instr_done
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle state of the internal buses
   initial begin
      {cpu_addr, cpu_data} = 32'h5a5a_a5a5;
      {cpu_exec, cpu_rd, cpu_wr, cpu_rte, cpu_instr_done} = 5'h00;
   end

   // one bus cycle: 0 exec, 1 read, 2 write; buses invert after release
   // so a stale value can never pass for a held one
   task bus(input int k, input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      cpu_addr <= a;
      cpu_data <= d;
      cpu_exec <= (k == 0);
      cpu_rd   <= (k == 1);
      cpu_wr   <= (k == 2);
      @(posedge clk);
      {cpu_exec, cpu_rd, cpu_wr} <= 3'h0;
      cpu_addr <= ~a;
      cpu_data <= ~d;
   endtask : bus

   // one-cycle pulse of return-from-exception or instruction-complete
   task pulse(input logic return_from_exception);
      @(posedge clk);
      cpu_rte        <= return_from_exception;
      cpu_instr_done <= !return_from_exception;
      @(posedge clk);
      {cpu_rte, cpu_instr_done} <= 2'h0;
   endtask : pulse
endmodule : abu_cpu_model

//--- verification/testbench.sv
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module testbench
   import abu_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [ABU_AW-1:0] A_CTRL = {ABU_IDX_CTRL, 2'b00};
   localparam logic [ABU_AW-1:0] A_STAT = {ABU_IDX_STAT, 2'b00};
   localparam logic [ABU_AW-1:0] A_BAR  = {ABU_IDX_BADDR, 2'b00};
   localparam logic [ABU_AW-1:0] A_EVT  = {ABU_IDX_EVT, 2'b00};
   localparam logic [ABU_AW-1:0] A_MSK  = {ABU_IDX_EMASK, 2'b00};
   localparam logic [ABU_AW-1:0] A_BDT  = {ABU_IDX_BDATA, 2'b00};
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr, err, m_flag, m_ie;
   logic [ABU_AW-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd, w;
   logic [15:0]       cpu_addr, cpu_data, baddr;
   logic              cpu_exec, cpu_rd, cpu_wr, cpu_rte, cpu_instr_done, rte_mask, break_irq, irq;
   integer            n_mismatch, total_checks, seed;
   logic [15:0]       bdata, ca, cd;
   logic [7:0]        ctl;
   logic              m;
   logic [31:0]       r;
   integer            k, i;

   abu_top abu_top_i (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_exec(cpu_exec), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
      .cpu_rte(cpu_rte), .cpu_instr_done(cpu_instr_done), .rte_mask(rte_mask), .break_irq(break_irq),
      .irq(irq));
   abu_cpu_model abu_cpu_model_i (.clk(clk), .cpu_addr(cpu_addr), .cpu_data(cpu_data),
      .cpu_exec(cpu_exec), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_rte(cpu_rte),
      .cpu_instr_done(cpu_instr_done));

   // -------------------------------------------
   // clock, watchdog and closing
   // -------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #100000;
      n_mismatch++;
      end_sim();
   end
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   // -------------------------------------------
   // apb master: request held until pready is sampled high
   // -------------------------------------------
   task apb(input logic wr, input logic [ABU_AW-1:0] a, input logic [31:0] d);
      integer n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      `CHK("apb answer", 1, n < 20)
   endtask : apb
   task chk_stat;
      apb(1'b0, A_STAT, 32'h0);
      `CHK("status", {24'h0, m_flag, m_ie, 6'h3f}, rd)
   endtask : chk_stat
   task settle;
      @(posedge clk);
      #1;
   endtask : settle

   // reference break decision from the cycle, address and data codes
   function automatic logic exp_match(input logic [7:0] c, input int kind, input logic [15:0] ad, input logic [15:0] dt);
      logic cyc, adr, dat;
      case (c[ABU_CSEL_HI:ABU_CSEL_LO])
         ABU_CSEL_EXEC: cyc = (kind == 0);
         ABU_CSEL_RD:   cyc = (kind == 1);
         ABU_CSEL_WR:   cyc = (kind == 2);
         default:       cyc = (kind == 1) || (kind == 2);
      endcase
      adr = (c[ABU_ACMP_HI:ABU_ACMP_LO] == ABU_ACMP_FULL) ? (ad == baddr) : (ad[15:8] == baddr[15:8]);
      case (c[ABU_DCMP_HI:ABU_DCMP_LO])
         ABU_DCMP_NONE: dat = 1'b1;
         ABU_DCMP_LOW:  dat = (dt[7:0] == bdata[7:0]);
         ABU_DCMP_HIGH: dat = (dt[15:8] == bdata[15:8]);
         default:       dat = (dt == bdata);
      endcase
      exp_match = cyc && adr && dat;
   endfunction : exp_match

   // -------------------------------------------
   // main sequence
   // -------------------------------------------
   initial begin
      {n_mismatch, total_checks, seed} = {32'd0, 32'd0, 32'd54};
      {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {m_flag, m_ie} = 2'b00;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      apb(1'b0, A_CTRL, 32'h0);
      `CHK("ctrl reset", 32'h0, rd)
      chk_stat();
      apb(1'b0, 18'h00010, 32'h0);
      `CHK("unmapped err", 1'b1, err)
      // break address keeps 16 bits, upper bits read zero
      w = $random(seed);
      baddr = w[15:0];
      apb(1'b1, A_BAR, w);
      apb(1'b0, A_BAR, 32'h0);
      `CHK("break addr", {16'h0, baddr}, rd)
      apb(1'b1, A_CTRL, 32'h0);
      apb(1'b1, A_STAT, 32'h40);
      m_ie = 1'b1;
      // near misses: one address bit off, or a non-execution cycle
      abu_cpu_model_i.bus(0, baddr ^ 16'h0001, $random(seed));
      #1 `CHK("miss lsb", 1'b0, break_irq)
      abu_cpu_model_i.bus(0, baddr ^ 16'h8000, $random(seed));
      #1 `CHK("miss msb", 1'b0, break_irq)
      abu_cpu_model_i.bus(1, baddr, $random(seed));
      #1 `CHK("read cycle", 1'b0, break_irq)
      abu_cpu_model_i.bus(2, baddr, $random(seed));
      #1 `CHK("write cycle", 1'b0, break_irq)
      // execution hit with arbitrary data must break
      abu_cpu_model_i.bus(0, baddr, $random(seed));
      m_flag = 1'b1;
      #1 `CHK("hit", 1'b1, break_irq)
      `CHK("irq", 1'b1, irq)
      // zero write without a prior read of one is refused
      apb(1'b1, A_STAT, 32'h40);
      chk_stat();
      apb(1'b1, A_STAT, 32'h40);
      m_flag = 1'b0;
      chk_stat();
      `CHK("cleared", 1'b0, break_irq)
      // enable off: flag still sets, request stays masked
      apb(1'b1, A_STAT, 32'h0);
      m_ie = 1'b0;
      abu_cpu_model_i.bus(0, baddr, $random(seed));
      m_flag = 1'b1;
      #1 `CHK("masked", 1'b0, break_irq)
      chk_stat();
      // event status, mask and write-one clear
      apb(1'b1, A_MSK, 32'h1);
      settle();
      `CHK("evt irq", 1'b1, irq)
      apb(1'b0, A_EVT, 32'h0);
      `CHK("evt", 32'h1, rd)
      apb(1'b1, A_EVT, 32'h1);
      settle();
      `CHK("evt clr", 1'b0, irq)
      // hold-off after return lasts until one instruction completes
      abu_cpu_model_i.pulse(1'b1);
      #1 `CHK("rte mask", 1'b1, rte_mask)
      repeat (3) @(posedge clk);
      #1 `CHK("rte hold", 1'b1, rte_mask)
      abu_cpu_model_i.pulse(1'b0);
      settle();
      `CHK("rte end", 1'b0, rte_mask)
      apb(1'b1, A_CTRL, 32'h80);
      abu_cpu_model_i.pulse(1'b1);
      #1 `CHK("rte off", 1'b0, rte_mask)
      // clear the flag left from the masked case, enable requests again
      apb(1'b1, A_STAT, 32'h40);
      {m_flag, m_ie} = 2'b01;
      chk_stat();
      // random codes: cycle kind, page or exact address, byte-wise data
      for (i = 0; i < 32; i++) begin
         w     = $random(seed);
         r     = $random(seed);
         ctl   = {1'b1, w[6:0]};
         bdata = w[31:16];
         ca    = baddr ^ {7'h00, r[0] & r[1], 7'h00, r[2] & r[3]};
         cd    = bdata ^ {7'h00, r[4] & r[5], 7'h00, r[6] & r[7]};
         k     = int'(r[9:8]);
         apb(1'b1, A_CTRL, {24'h0, ctl});
         apb(1'b1, A_BDT, {16'h0, bdata});
         m = exp_match(ctl, k, ca, cd);
         abu_cpu_model_i.bus(k, ca, cd);
         m_flag = m;
         #1 `CHK("rnd break", m, break_irq)
         chk_stat();
         apb(1'b1, A_STAT, 32'h40);
         m_flag = 1'b0;
      end
      // reset in mid-run with the flag set brings everything back to zero
      apb(1'b1, A_CTRL, 32'h0);
      abu_cpu_model_i.bus(0, baddr, cd);
      #1 `CHK("pre reset", 1'b1, break_irq)
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      {m_flag, m_ie} = 2'b00;
      chk_stat();
      `CHK("reset irq", 1'b0, irq)
      end_sim();
   end
endmodule : testbench
